/* File: verilog/nvsram_pkg.sv */
package nvsram_pkg;

   // ==========================================================
   // Array geometry
   localparam int ADDR_W    = 13;
   localparam int MEM_DEPTH = 8192;
   localparam logic [ADDR_W-1:0] QUARTER_BASE = 13'h1800;
   localparam logic [ADDR_W-1:0] HALF_BASE    = 13'h1000;

   // ==========================================================
   // Opcodes (values are arbitrary)
   localparam logic [7:0] OP_WRITE_STATUS = 8'h01;
   localparam logic [7:0] OP_WRITE        = 8'h02;
   localparam logic [7:0] OP_READ         = 8'h03;
   localparam logic [7:0] OP_WRITE_DISABLE_CMD  = 8'h04;
   localparam logic [7:0] OP_READ_STATUS  = 8'h05;
   localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
   localparam logic [7:0] OP_STORE        = 8'hA0;
   localparam logic [7:0] OP_RECALL       = 8'hA1;
   localparam logic [7:0] OP_AUTOSAVE_DISABLE_CMD = 8'hA2;
   localparam logic [7:0] OP_AUTOSAVE_ENABLE_CMD  = 8'hA3;

   // ==========================================================
   // Status byte layout
   localparam int ST_BUSY_BIT  = 0;
   localparam int ST_WEL_BIT   = 1;
   localparam int ST_BP_LO_BIT = 2;
   localparam int ST_BP_HI_BIT = 3;
   localparam logic [1:0] BP_RESET = 2'h0;

   // ==========================================================
   // Timing at 250 MHz
   localparam int CLK_PERIOD_PS         = 4000;
   localparam int STORE_TIME_NS         = 8000;
   localparam int RECALL_TIME_NS        = 4000;
   localparam int BUSY_RELEASE_DRIVE_TIME_NS = 20;
   localparam logic [15:0] STORE_CYCLES =
      16'((STORE_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
   localparam logic [15:0] RECALL_CYCLES =
      16'((RECALL_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
   localparam logic [15:0] RELEASE_CYCLES =
      16'((BUSY_RELEASE_DRIVE_TIME_NS * 1000) / CLK_PERIOD_PS);

   // ==========================================================
   // State encodings
   typedef enum logic [6:0] {
      SP_CMD    = 7'h01,
      SP_ADDR   = 7'h02,
      SP_WDATA  = 7'h04,
      SP_RDATA  = 7'h08,
      SP_SRREAD = 7'h10,
      SP_SRWR   = 7'h20,
      SP_IGNORE = 7'h40
   } spi_state_e;

   typedef enum logic [3:0] {
      NV_IDLE    = 4'h1,
      NV_STORE   = 4'h2,
      NV_RECALL  = 4'h4,
      NV_RELEASE = 4'h8
   } nv_state_e;

endpackage : nvsram_pkg

/* File: verilog/nvsram_spi_slave.sv */
module nvsram_spi_slave (
   input  wire logic i_clk,
   input  wire logic i_reset,
   input  wire logic i_sck,
   input  wire logic i_cs_n,
   input  wire logic i_si,
   input  wire logic i_hold_n,
   input  wire logic i_write_protect_n,
   input  wire logic i_power_fail,
   input  wire logic i_store_busy_pin,
   output logic      o_store_busy_pin,
   output logic      o_store_busy_pin_oe_n,
   output logic      o_so,
   output logic      o_so_oe_n,
   output logic      o_busy
);

   // ==========================================================
   // Link side: frame state (serial clock domain)
   nvsram_pkg::spi_state_e             state, next_state;
   logic [2:0]                         bitcnt, next_bitcnt;
   logic [6:0]                         shift, next_shift;
   logic [nvsram_pkg::ADDR_W-1:0]      addr, next_addr;
   logic                               addr_hi, next_addr_hi;
   logic                               is_write, next_is_write;
   logic [7:0]                         tx, next_tx;
   logic [7:0]                         rx;
   logic                               frame_rst;
   logic                               mem_we;
   logic                               do_wren, do_wdis, do_store, do_recall;
   logic                               do_asen, do_asdis, do_wrsr;
   logic                               prot_hit, access_ok;
   logic [7:0]                         status;
   logic [7:0]                         sram [nvsram_pkg::MEM_DEPTH];
   logic [7:0]                         nv   [nvsram_pkg::MEM_DEPTH];

   // Persistent link-side state and crossings
   logic       wel, next_wel;
   logic [1:0] bp, next_bp;
   logic       asdis, next_asdis;
   logic       st_req, next_st_req;
   logic       rc_req, next_rc_req;
   logic       wr_tog, next_wr_tog;
   logic [3:0] sck_s1, sck_s2;
   logic       wp_ok, busy_s, st_ack_s, rc_ack_s, pending;
   // Answers from the system side; declared here since the link side samples them
   logic       st_ack, next_st_ack;
   logic       rc_ack, next_rc_ack;
   logic       busy_q, next_busy_q;

   // Negedge output stage
   logic so_bit, so_drive;

   // Deselect ends the frame even though the serial clock stops
   assign frame_rst = i_reset | i_cs_n;
   assign rx        = {shift, i_si};
   assign wp_ok     = sck_s2[0];
   assign busy_s    = sck_s2[1];
   assign st_ack_s  = sck_s2[2];
   assign rc_ack_s  = sck_s2[3];
   // Request in flight counts as busy until the other side answers
   assign pending   = (st_req != st_ack_s) | (rc_req != rc_ack_s);
   assign access_ok = ~busy_s & ~pending;
   assign status    = {4'h0, bp, wel, busy_s | pending};

   // Block protection compare on the current write address
   always_comb begin
      case (bp)
         2'h1:    prot_hit = (addr >= nvsram_pkg::QUARTER_BASE);
         2'h2:    prot_hit = (addr >= nvsram_pkg::HALF_BASE);
         2'h3:    prot_hit = 1'b1;
         default: prot_hit = 1'b0;
      endcase
   end

   // Frame sequencer: bit counting, decode, address and data
   always_comb begin
      next_state    = state;
      next_bitcnt   = bitcnt;
      next_shift    = shift;
      next_addr     = addr;
      next_addr_hi  = addr_hi;
      next_is_write = is_write;
      next_tx       = tx;
      mem_we        = 1'b0;
      do_wren       = 1'b0;
      do_wdis       = 1'b0;
      do_store      = 1'b0;
      do_recall     = 1'b0;
      do_asen       = 1'b0;
      do_asdis      = 1'b0;
      do_wrsr       = 1'b0;
      if (i_hold_n) begin
         next_bitcnt = bitcnt + 3'h1;
         next_shift  = rx[6:0];
         if (bitcnt == 3'h7) begin
            case (state)
               nvsram_pkg::SP_CMD: begin
                  next_state = nvsram_pkg::SP_IGNORE;
                  case (rx)
                     nvsram_pkg::OP_READ, nvsram_pkg::OP_WRITE: begin
                        next_is_write = (rx == nvsram_pkg::OP_WRITE);
                        if (access_ok) begin
                           next_state = nvsram_pkg::SP_ADDR;
                        end
                     end
                     nvsram_pkg::OP_READ_STATUS: begin
                        next_state = nvsram_pkg::SP_SRREAD;
                        next_tx    = status;
                     end
                     nvsram_pkg::OP_WRITE_STATUS: next_state = nvsram_pkg::SP_SRWR;
                     nvsram_pkg::OP_WRITE_ENABLE: do_wren = 1'b1;
                     nvsram_pkg::OP_WRITE_DISABLE_CMD: do_wdis = 1'b1;
                     nvsram_pkg::OP_STORE:        do_store = access_ok;
                     nvsram_pkg::OP_RECALL:       do_recall = access_ok;
                     nvsram_pkg::OP_AUTOSAVE_ENABLE_CMD:  do_asen = 1'b1;
                     nvsram_pkg::OP_AUTOSAVE_DISABLE_CMD: do_asdis = 1'b1;
                     default: ;
                  endcase
               end
               nvsram_pkg::SP_ADDR: begin
                  next_addr_hi = 1'b1;
                  if (addr_hi) begin
                     next_state = is_write ? nvsram_pkg::SP_WDATA
                                           : nvsram_pkg::SP_RDATA;
                     next_tx    = sram[{addr[nvsram_pkg::ADDR_W-2:0], i_si}];
                  end
               end
               nvsram_pkg::SP_WDATA: begin
                  mem_we    = wel & wp_ok & ~prot_hit & access_ok;
                  next_addr = addr + 13'h0001;
               end
               nvsram_pkg::SP_RDATA: begin
                  next_addr = addr + 13'h0001;
                  next_tx   = sram[addr + 13'h0001];
               end
               nvsram_pkg::SP_SRREAD: next_tx = status;
               nvsram_pkg::SP_SRWR: begin
                  do_wrsr    = wel & wp_ok;
                  next_state = nvsram_pkg::SP_IGNORE;
               end
               default: ;
            endcase
         end
         // Address bits shift through a 13-bit register, upper bits fall off
         if (state == nvsram_pkg::SP_ADDR) begin
            next_addr = {addr[nvsram_pkg::ADDR_W-2:0], i_si};
         end
      end
   end

   always_ff @(posedge i_sck or posedge frame_rst) begin
      if (frame_rst) begin
         state    <= nvsram_pkg::SP_CMD;
         bitcnt   <= 3'h0;
         shift    <= 7'h00;
         addr     <= 13'h0000;
         addr_hi  <= 1'b0;
         is_write <= 1'b0;
         tx       <= 8'h00;
      end else begin
         state    <= next_state;
         bitcnt   <= next_bitcnt;
         shift    <= next_shift;
         addr     <= next_addr;
         addr_hi  <= next_addr_hi;
         is_write <= next_is_write;
         tx       <= next_tx;
      end
   end

   // Persistent status bits and request toggles
   always_comb begin
      next_wel    = wel;
      next_bp     = bp;
      next_asdis  = asdis;
      next_st_req = st_req ^ do_store;
      next_rc_req = rc_req ^ do_recall;
      next_wr_tog = wr_tog ^ mem_we;
      if (do_wren) begin
         next_wel = 1'b1;
      end
      if (do_wdis) begin
         next_wel = 1'b0;
      end
      if (do_asen) begin
         next_asdis = 1'b0;
      end
      if (do_asdis) begin
         next_asdis = 1'b1;
      end
      if (do_wrsr) begin
         next_bp = {rx[nvsram_pkg::ST_BP_HI_BIT], rx[nvsram_pkg::ST_BP_LO_BIT]};
      end
   end

   always_ff @(posedge i_sck or posedge i_reset) begin
      if (i_reset) begin
         wel    <= 1'b0;
         bp     <= nvsram_pkg::BP_RESET;
         asdis  <= 1'b0;
         st_req <= 1'b0;
         rc_req <= 1'b0;
         wr_tog <= 1'b0;
         sck_s1 <= 4'h0;
         sck_s2 <= 4'h0;
      end else begin
         wel    <= next_wel;
         bp     <= next_bp;
         asdis  <= next_asdis;
         st_req <= next_st_req;
         rc_req <= next_rc_req;
         wr_tog <= next_wr_tog;
         sck_s1 <= {rc_ack, st_ack, busy_q, i_write_protect_n};
         sck_s2 <= sck_s1;
      end
   end

   // Array: serial writes, or whole recall from the nonvolatile copy.
   // The nonvolatile copy is quiet here: no store can run while recall is taken.
   always_ff @(posedge i_sck) begin
      if (do_recall) begin
         sram <= nv;
      end else if (mem_we) begin
         sram[addr] <= rx;
      end
   end

   // Output stage on the falling edge; works for both idle levels of sclk
   always_ff @(negedge i_sck or posedge frame_rst) begin
      if (frame_rst) begin
         so_bit   <= 1'b0;
         so_drive <= 1'b0;
      end else begin
         so_bit   <= tx[~bitcnt];
         so_drive <= (state == nvsram_pkg::SP_RDATA) | (state == nvsram_pkg::SP_SRREAD);
      end
   end

   assign o_so      = so_bit;
   assign o_so_oe_n = ~(so_drive & i_hold_n & ~i_cs_n);

   // ==========================================================
   // System side: nonvolatile sequencer (i_clk domain)
   nvsram_pkg::nv_state_e nv_state, next_nv_state;
   logic [15:0] cnt, next_cnt;
   logic        dirty, next_dirty;
   logic        wr_seen;
   logic        sb_out, sb_oe_n;
   logic [5:0]  clk_s1, clk_s2;
   logic        st_pend, rc_pend, wr_evt, hw_req, auto_req, store_copy;

   assign st_pend  = clk_s2[0] != st_ack;
   assign rc_pend  = clk_s2[1] != rc_ack;
   assign wr_evt   = clk_s2[2] != wr_seen;
   assign hw_req   = ~clk_s2[5];
   assign auto_req = clk_s2[4] & ~clk_s2[3];

   always_comb begin
      next_nv_state = nv_state;
      next_cnt      = cnt + 16'h0001;
      next_st_ack   = st_ack;
      next_rc_ack   = rc_ack;
      next_dirty    = dirty;
      store_copy    = 1'b0;
      case (nv_state)
         nvsram_pkg::NV_IDLE: begin
            next_cnt = 16'h0000;
            if (rc_pend) begin
               next_rc_ack   = clk_s2[1];
               next_dirty    = 1'b0;
               next_nv_state = nvsram_pkg::NV_RECALL;
            end else if (st_pend || ((hw_req || auto_req) && dirty)) begin
               next_st_ack   = clk_s2[0];
               next_dirty    = 1'b0;
               store_copy    = 1'b1;
               next_nv_state = nvsram_pkg::NV_STORE;
            end
         end
         nvsram_pkg::NV_STORE: begin
            if (cnt == nvsram_pkg::STORE_CYCLES - 16'h0001) begin
               next_cnt      = 16'h0000;
               next_nv_state = nvsram_pkg::NV_RELEASE;
            end
         end
         nvsram_pkg::NV_RECALL: begin
            if (cnt == nvsram_pkg::RECALL_CYCLES - 16'h0001) begin
               next_nv_state = nvsram_pkg::NV_IDLE;
            end
         end
         nvsram_pkg::NV_RELEASE: begin
            if (cnt == nvsram_pkg::RELEASE_CYCLES - 16'h0001) begin
               next_nv_state = nvsram_pkg::NV_IDLE;
            end
         end
         default: next_nv_state = nvsram_pkg::NV_IDLE;
      endcase
      // A write landing with the clear is kept
      if (wr_evt) begin
         next_dirty = 1'b1;
      end
      // External low on the pin also inhibits access
      next_busy_q = (next_nv_state != nvsram_pkg::NV_IDLE) | hw_req;
   end

   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         nv_state <= nvsram_pkg::NV_IDLE;
         cnt      <= 16'h0000;
         dirty    <= 1'b0;
         st_ack   <= 1'b0;
         rc_ack   <= 1'b0;
         wr_seen  <= 1'b0;
         busy_q   <= 1'b0;
         sb_out   <= 1'b0;
         sb_oe_n  <= 1'b1;
         clk_s1   <= 6'h20;
         clk_s2   <= 6'h20;
      end else begin
         nv_state <= next_nv_state;
         cnt      <= next_cnt;
         dirty    <= next_dirty;
         st_ack   <= next_st_ack;
         rc_ack   <= next_rc_ack;
         wr_seen  <= clk_s2[2];
         busy_q   <= next_busy_q;
         sb_out   <= (next_nv_state == nvsram_pkg::NV_RELEASE);
         sb_oe_n  <= (next_nv_state == nvsram_pkg::NV_IDLE);
         clk_s1   <= {i_store_busy_pin, i_power_fail, asdis, wr_tog, rc_req, st_req};
         clk_s2   <= clk_s1;
      end
   end

   // Whole-array copy in one edge; the array is static while a store is taken
   always_ff @(posedge i_clk) begin
      if (store_copy) begin
         nv <= sram;
      end
   end

   assign o_store_busy_pin      = sb_out;
   assign o_store_busy_pin_oe_n = sb_oe_n;
   assign o_busy                = (nv_state != nvsram_pkg::NV_IDLE);

   // ==========================================================
   // Checks
   AST_STORE_DRIVES_LOW:
   assert property (@(posedge i_clk) disable iff (i_reset)
      (nv_state == nvsram_pkg::NV_STORE) && $past(nv_state == nvsram_pkg::NV_STORE)
      |-> !o_store_busy_pin && !o_store_busy_pin_oe_n)
   else $error("store-busy pin not driven low during store");

   AST_RELEASE_DRIVES_HIGH:
   assert property (@(posedge i_clk) disable iff (i_reset)
      $rose(nv_state == nvsram_pkg::NV_RELEASE)
      |-> (o_store_busy_pin && !o_store_busy_pin_oe_n) [*5] ##1 o_store_busy_pin_oe_n)
   else $error("store-busy pin release pulse wrong");

   AST_HW_STORE_NEEDS_WRITE:
   assert property (@(posedge i_clk) disable iff (i_reset)
      (nv_state == nvsram_pkg::NV_IDLE) && !dirty && !st_pend && !rc_pend
      |=> nv_state == nvsram_pkg::NV_IDLE)
   else $error("store started with no write since last store");

   AST_BUSY_VISIBLE:
   assert property (@(posedge i_clk) disable iff (i_reset)
      (nv_state != nvsram_pkg::NV_IDLE) |-> o_busy && busy_q)
   else $error("busy not shown while transfer runs");

   AST_NO_WRITE_WHILE_BUSY:
   assert property (@(posedge i_sck) disable iff (frame_rst)
      mem_we |-> !busy_s && !pending && wel && wp_ok)
   else $error("array write while busy or protected");

   AST_BLOCK_PROTECT:
   assert property (@(posedge i_sck) disable iff (frame_rst)
      (bp == 2'h3) |-> !mem_we)
   else $error("write into fully protected array");

   AST_BURST_WRAP:
   assert property (@(posedge i_sck) disable iff (frame_rst)
      (state == nvsram_pkg::SP_RDATA) && i_hold_n && (bitcnt == 3'h7) && (addr == 13'h1FFF)
      |=> addr == 13'h0000)
   else $error("burst address did not wrap to zero");

   AST_HOLD_FREEZES:
   assert property (@(posedge i_sck) disable iff (frame_rst)
      !i_hold_n |=> $stable(state) && $stable(bitcnt) && $stable(addr))
   else $error("transfer advanced during hold");

   AST_SO_FLOATS:
   assert property (@(posedge i_sck) disable iff (i_reset)
      (i_cs_n || (state == nvsram_pkg::SP_WDATA)) |-> o_so_oe_n)
   else $error("serial output driven when not returning data");

endmodule : nvsram_spi_slave

/* File: verification/spi_master_model.sv */
module spi_master_model (
   output logic      o_sck,
   output logic      o_cs_n,
   output logic      o_si,
   input  wire logic i_so,
   input  wire logic i_so_oe_n
);
   timeunit 1ns;
   timeprecision 1ps;

   logic cpol;
   logic drv;

   // ==========================================================
   // Idle levels
   // Clock parked low, device deselected
   initial begin
      cpol   = 1'b0;
      drv    = 1'b0;
      o_sck  = 1'b0;
      o_cs_n = 1'b1;
      o_si   = 1'b0;
   end

   // ==========================================================
   // Frame tasks
   // Clock parks at its polarity; only modes 0 and 3 offered
   task automatic open_frame(input logic mode3);
      cpol   = mode3;
      o_sck  = mode3;
      drv    = 1'b0;
      #20 o_cs_n = 1'b0;
      #15;
   endtask : open_frame

   // Data set with clock low, read at the rise, MSB first
   task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
      for (int i = 7; i >= 0; i--) begin
         o_sck = 1'b0;
         o_si  = tx[i];
         #15 o_sck = 1'b1;
         rx[i] = i_so;
         drv   = drv | ~i_so_oe_n;
         #15;
      end
   endtask : xfer

   // Released data line shows the inverse, not a stale bit
   task automatic close_frame();
      o_sck = cpol;
      #10 o_cs_n = 1'b1;
      o_si = ~o_si;
      #30;
   endtask : close_frame
endmodule : spi_master_model

/* File: verification/tb_nvsram_spi_slave.sv */
module tb_nvsram_spi_slave;
   timeunit 1ns;
   timeprecision 1ps;

   localparam int LIMIT = 40000;
   localparam logic [15:0] BND [3] = '{16'h1800, 16'h1000, 16'h0000};

   logic       clk     = 1'b0;
   logic       rst     = 1'b1;
   logic       hold_n  = 1'b1;
   logic       wp_n    = 1'b1;
   logic       pfail   = 1'b0;
   logic       ext_low = 1'b0;
   logic       mode3   = 1'b0;
   logic       sck, cs_n, si, so, so_oe_n, sb, sb_oe_n, busy;
   logic       sb_line;
   logic       so_line;
   logic [7:0] rx [4];
   int         errors  = 0;
   int         checked = 0;
   int         cycles  = 0;

   // ==========================================================
   // Clock, wires, timeout
   always #2 clk = ~clk;
   // Weak pull-up on the busy wire; external low asks for a store
   assign sb_line = !sb_oe_n ? sb : !ext_low;
   assign so_line = so_oe_n ? ~so : so;
   // Hang guard
   always @(posedge clk) begin
      cycles++;
      if (cycles == LIMIT) begin
         errors++;
         summarize();
      end
   end

   nvsram_spi_slave dut_u (
      .i_clk                 (clk),
      .i_reset               (rst),
      .i_sck                 (sck),
      .i_cs_n                (cs_n),
      .i_si                  (si),
      .i_hold_n              (hold_n),
      .i_write_protect_n     (wp_n),
      .i_power_fail          (pfail),
      .i_store_busy_pin      (sb_line),
      .o_store_busy_pin      (sb),
      .o_store_busy_pin_oe_n (sb_oe_n),
      .o_so                  (so),
      .o_so_oe_n             (so_oe_n),
      .o_busy                (busy)
   );

   spi_master_model master_u (
      .o_sck     (sck),
      .o_cs_n    (cs_n),
      .o_si      (si),
      .i_so      (so_line),
      .i_so_oe_n (so_oe_n)
   );

   // ==========================================================
   // Shared tasks
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         errors++;
         $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   task automatic frame(input logic [7:0] op, input int nb, input logic [31:0] tail);
      logic [7:0] d;
      master_u.open_frame(mode3);
      master_u.xfer(op, d);
      for (int k = 0; k < nb; k++) begin
         master_u.xfer(tail[31-8*k -: 8], rx[k]);
      end
      master_u.close_frame();
   endtask : frame

   task automatic wr(input logic [15:0] a, input logic [15:0] d);
      frame(nvsram_pkg::OP_WRITE_ENABLE, 0, '0);
      frame(nvsram_pkg::OP_WRITE, 4, {a, d});
   endtask : wr

   task automatic rd(input logic [15:0] a, input logic [15:0] e);
      frame(nvsram_pkg::OP_READ, 4, {a, 16'h0000});
      check({rx[2], rx[3]}, e);
   endtask : rd

   task automatic rdsr(input logic [7:0] e);
      frame(nvsram_pkg::OP_READ_STATUS, 1, '0);
      check({8'h00, rx[0]}, {8'h00, e});
   endtask : rdsr

   task automatic wait_busy(input logic v, input int lim);
      int n;
      n = 0;
      while (busy !== v && n < lim) begin
         @(posedge clk);
         #1;
         n++;
      end
      check({15'h0000, busy}, {15'h0000, v});
   endtask : wait_busy

   // Length of a driven level on the busy wire, in clocks
   task automatic run_len(input logic lvl, output int n);
      n = 0;
      while (!sb_oe_n && sb === lvl && n < 3000) begin
         @(posedge clk);
         #1;
         n++;
      end
   endtask : run_len

   // Ten-clock low request or power warning, then settle
   task automatic pulse(input logic pin);
      @(posedge clk);
      if (pin) ext_low <= 1'b1;
      else pfail <= 1'b1;
      repeat (10) @(posedge clk);
      ext_low <= 1'b0;
      pfail   <= 1'b0;
      repeat (10) @(posedge clk);
      #1;
   endtask : pulse

   // ==========================================================
   // Scenarios
   task automatic t_wrap();
      wr(16'hFFFF, 16'hA53C);
      mode3 = 1'b1;
      rd(16'h1FFF, 16'hA53C);
      mode3 = 1'b0;
      rd(16'hDFFF, 16'hA53C);
      rdsr(8'h02);
   endtask : t_wrap

   task automatic t_store();
      int n;
      wr(16'h0100, 16'h1122);
      // Watcher starts before the command so the low run is counted whole
      fork
         begin
            wait_busy(1'b1, 400);
            check({14'h0000, sb_oe_n, sb}, 16'h0000);
            run_len(1'b0, n);
            check(n[15:0], nvsram_pkg::STORE_CYCLES);
            run_len(1'b1, n);
            check(n[15:0], nvsram_pkg::RELEASE_CYCLES);
            check({15'h0000, sb_oe_n}, 16'h0001);
         end
         begin
            frame(nvsram_pkg::OP_STORE, 0, '0);
            rdsr(8'h03);
            frame(nvsram_pkg::OP_READ, 4, '0);
            check({15'h0000, master_u.drv}, 16'h0000);
         end
      join
      wait_busy(1'b0, 100);
   endtask : t_store

   task automatic t_hw();
      pulse(1'b1);
      check({14'h0000, busy, sb_oe_n}, 16'h0001);
      wr(16'h0200, 16'h3344);
      pulse(1'b1);
      check({14'h0000, sb_oe_n, sb}, 16'h0000);
      wait_busy(1'b0, 3000);
   endtask : t_hw

   task automatic t_prot();
      @(posedge clk) wp_n <= 1'b0;
      wr(16'h0100, 16'h3333);
      @(posedge clk) wp_n <= 1'b1;
      rd(16'h0100, 16'h1122);
      for (int k = 0; k < 3; k++) begin
         wr(BND[k] - 16'h0001, {8'h10 + 8'(k), 8'h20 + 8'(k)});
         frame(nvsram_pkg::OP_WRITE_STATUS, 1, {4'h0, 2'(k + 1), 2'h0, 24'h0});
         rdsr({4'h0, 2'(k + 1), 2'h2});
         wr(BND[k] - 16'h0001, 16'hEEEE);
         rd(BND[k] - 16'h0001, {(k == 2) ? 8'h12 : 8'hEE, 8'h20 + 8'(k)});
         frame(nvsram_pkg::OP_WRITE_STATUS, 1, '0);
      end
      frame(nvsram_pkg::OP_WRITE_DISABLE_CMD, 0, '0);
      frame(nvsram_pkg::OP_WRITE, 4, {16'h0100, 16'h4444});
      rd(16'h0100, 16'h1122);
      rdsr(8'h00);
   endtask : t_prot

   task automatic t_auto();
      wr(16'h0400, 16'h7788);
      frame(nvsram_pkg::OP_AUTOSAVE_DISABLE_CMD, 0, '0);
      pulse(1'b0);
      check({14'h0000, busy, sb_oe_n}, 16'h0001);
      frame(nvsram_pkg::OP_AUTOSAVE_ENABLE_CMD, 0, '0);
      pulse(1'b0);
      check({14'h0000, busy, sb_oe_n}, 16'h0002);
      wait_busy(1'b0, 3000);
      wr(16'h0100, 16'h5A5A);
      frame(nvsram_pkg::OP_RECALL, 0, '0);
      wait_busy(1'b1, 200);
      wait_busy(1'b0, 2000);
      rd(16'h0100, 16'h1122);
   endtask : t_auto

   task automatic t_hold();
      logic [7:0] d;
      frame(nvsram_pkg::OP_WRITE_ENABLE, 0, '0);
      master_u.open_frame(1'b0);
      master_u.xfer(nvsram_pkg::OP_WRITE, d);
      master_u.xfer(8'h03, d);
      @(posedge clk) hold_n <= 1'b0;
      master_u.xfer(8'hFF, d);
      @(posedge clk) hold_n <= 1'b1;
      master_u.xfer(8'h00, d);
      master_u.xfer(8'hC3, d);
      master_u.xfer(8'h96, d);
      master_u.close_frame();
      rd(16'h0300, 16'hC396);
   endtask : t_hold

   task automatic t_standby();
      logic [7:0] d;
      master_u.xfer(nvsram_pkg::OP_WRITE, d);
      master_u.xfer(8'h03, d);
      master_u.close_frame();
      check({15'h0000, so_oe_n}, 16'h0001);
      rd(16'h0300, 16'hC396);
   endtask : t_standby

   // ==========================================================
   // Verdict
   task automatic summarize();
      $display("errors=%0d checked=%0d", errors, checked);
      if (errors == 0 && checked > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : summarize

   // Main sequence; busy sequences need the earlier writes
   initial begin
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      repeat (4) @(posedge clk);
      t_wrap();
      t_store();
      t_hw();
      t_prot();
      t_auto();
      t_hold();
      t_standby();
      summarize();
   end
endmodule : tb_nvsram_spi_slave
